// [core/tcp_timer.sv]
// How it works
// [R01] timer mode: counter steps on each tick of the internal prescaled clock
// [R02] counter mode: counter steps on rising edges of the external count pin
// [R03] timer/counter: match raises interrupt, clears counter, counting continues
// [R04] divider mode: each match toggles output flip-flop and clears counter
// [R05] divider pin shows inverse of flip-flop, a 50% square wave
// [R06] flip-flop resets to 0 and software may preset it
// [R07] divider mode: interrupt on every divider pin level change
// [R08] pwm mode: match toggles flip-flop, counter keeps running
// [R09] pwm mode: overflow toggles flip-flop again and restarts period
// [R10] pwm pin shows inverse of flip-flop
// [R11] pwm mode: interrupt on overflow only, never on match
// [R12] pwm match is double-buffered, new value taken at period end
// [R13] setting the run bit loads written match into the active stage
// [R14] counter and match are 8 bits, overflow is all-ones to zero
// [R15] counter holds while run bit is 0, counts while it is 1
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tcp_timer
  import tcp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // wishbone slave
  input  wire tcp_pkg::tcp_wb_req_t wb_req,
  output var tcp_pkg::tcp_wb_rsp_t  wb_rsp,
  // pins
  input  wire logic                 external_count_input,
  output logic                      divider_output_pin,
  output logic                      pwm_output_pin,
  output logic                      timer_irq
);
  import tcp_pkg::*;

  // -------------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------------
  if (WIDTH != 8) begin : g_bad_width
    $error("tcp_timer: only an 8-bit counter is supported");
  end

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  tcp_mode_t   mode_q;
  logic        timer_run_bit_q;
  logic [3:0]  pre_sel_q;
  logic [7:0]  period_match_register_q;
  logic [7:0]  period_match_register_alias_q;
  logic [7:0]  count_q;
  logic        ff_q;
  logic        irq_flag_q;
  logic [15:0] pre_cnt_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        div_pin_q;
  logic        pwm_pin_q;
  logic        irq_q;

  logic        ext_rise;
  logic        tick;
  logic        step;
  logic        hit;
  logic        ovf;
  logic        wr_ctrl;
  logic        wr_match;
  logic        wr_stat;
  logic        acc;
  logic        wr_acc;
  logic        run_rise;
  logic        ff_toggle;
  logic        ff_preset;
  logic        ev_irq;

  tcp_pin_sync u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (external_count_input),
    .rise  (ext_rise)
  );

  // -------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------
  // one wait state: ack follows the request edge, then drops for a cycle
  // writes land on the edge where the master samples ack, never earlier
  assign acc      = wb_req.cyc && wb_req.stb && !ack_q;
  assign wr_acc   = wb_req.cyc && wb_req.stb && ack_q && wb_req.we && wb_req.sel[0];
  assign wr_ctrl  = wr_acc && (wb_req.adr == TCP_OFF_CTRL);
  assign wr_match = wr_acc && (wb_req.adr == TCP_OFF_MATCH);
  assign wr_stat  = wr_acc && (wb_req.adr == TCP_OFF_STAT);
  assign run_rise = wr_ctrl && wb_req.dat[TCP_CTRL_RUN_POS] && !timer_run_bit_q;
  assign ff_preset = wr_ctrl && wb_req.sel[1] && wb_req.dat[TCP_CTRL_FFSET_POS];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdat_q <= 32'h0;
    end else if (acc) begin
      unique case (wb_req.adr)
        TCP_OFF_CTRL:  rdat_q <= {24'h0, pre_sel_q, 1'b0, mode_q, timer_run_bit_q};
        TCP_OFF_MATCH: rdat_q <= {24'h0, period_match_register_q};
        TCP_OFF_STAT:  rdat_q <= {30'h0, ff_q, irq_flag_q};
        TCP_OFF_COUNT: rdat_q <= {24'h0, count_q};
        default:       rdat_q <= 32'h0;
      endcase
    end
  end

  assign wb_rsp = '{dat: rdat_q, ack: ack_q};

  // -------------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_run_bit_q <= 1'b0;
      mode_q          <= TCP_MODE_TIMER;
      pre_sel_q       <= TCP_PRE_RST;
    end else if (wr_ctrl) begin
      timer_run_bit_q <= wb_req.dat[TCP_CTRL_RUN_POS];
      mode_q          <= tcp_mode_t'(wb_req.dat[TCP_CTRL_MODE_POS +: 2]);
      pre_sel_q       <= wb_req.dat[TCP_CTRL_PRE_POS +: 4];
    end
  end

  // software-written stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      period_match_register_q <= TCP_MATCH_RST;
    end else if (wr_match) begin
      period_match_register_q <= wb_req.dat[7:0];
    end
  end

  // active stage: outside pwm it tracks writes directly; in pwm it
  // only moves at period end or when the run bit is set, so duty changes never glitch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      period_match_register_alias_q <= TCP_MATCH_RST;
    end else if (run_rise) begin
      period_match_register_alias_q <= period_match_register_q; // R13
    end else if (mode_q == TCP_MODE_PWM) begin
      if (step && ovf) begin
        period_match_register_alias_q <= period_match_register_q; // R12
      end
    end else begin
      period_match_register_alias_q <= period_match_register_q;
    end
  end

  // -------------------------------------------------------------------
  // prescaler: tick every 2^pre_sel cycles
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_q <= 16'h0;
    end else if (!timer_run_bit_q) begin
      pre_cnt_q <= 16'h0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 16'h1;
    end
  end

  always_comb begin
    tick = 1'b0;
    if (pre_sel_q == 4'h0) begin
      tick = 1'b1;
    end else begin
      tick = (pre_cnt_q & ((16'h1 << pre_sel_q) - 16'h1)) == 16'h0;
    end
  end

  // -------------------------------------------------------------------
  // counter
  // -------------------------------------------------------------------
  assign step = timer_run_bit_q && ((mode_q == TCP_MODE_COUNTER) ? ext_rise : tick); // R01 R02 R15
  assign hit  = (count_q == period_match_register_alias_q);
  assign ovf  = (count_q == 8'hff); // R14

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 8'h0;
    end else if (step) begin
      unique case (mode_q)
        TCP_MODE_TIMER, TCP_MODE_COUNTER, TCP_MODE_DIVIDER: begin
          count_q <= hit ? 8'h0 : count_q + 8'h1; // R03 R04
        end
        TCP_MODE_PWM: begin
          count_q <= count_q + 8'h1; // R08 R09 R14
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // output flip-flop
  // -------------------------------------------------------------------
  always_comb begin
    ff_toggle = 1'b0;
    if (step && mode_q == TCP_MODE_DIVIDER) begin
      ff_toggle = hit; // R04
    end else if (step && mode_q == TCP_MODE_PWM) begin
      // match at all-ones coincides with overflow: both toggles cancel
      ff_toggle = hit ^ ovf; // R08 R09
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff_q <= 1'b0; // R06
    end else if (ff_preset) begin
      ff_q <= wb_req.dat[TCP_CTRL_FFVAL_POS]; // R06
    end else if (ff_toggle) begin
      ff_q <= ~ff_q;
    end
  end

  // -------------------------------------------------------------------
  // interrupt flag, write one to clear, set wins
  // -------------------------------------------------------------------
  always_comb begin
    ev_irq = 1'b0;
    if (step) begin
      unique case (mode_q)
        TCP_MODE_TIMER, TCP_MODE_COUNTER: ev_irq = hit; // R03
        TCP_MODE_DIVIDER:                 ev_irq = hit; // R07
        TCP_MODE_PWM:                     ev_irq = ovf; // R11
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag_q <= 1'b0;
    end else if (ev_irq) begin
      irq_flag_q <= 1'b1;
    end else if (wr_stat && wb_req.dat[TCP_STAT_IRQ_POS]) begin
      irq_flag_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // registered pins
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_pin_q <= 1'b1;
      pwm_pin_q <= 1'b1;
      irq_q     <= 1'b0;
    end else begin
      div_pin_q <= ~ff_q; // R05
      pwm_pin_q <= ~ff_q; // R10
      irq_q     <= irq_flag_q;
    end
  end

  assign divider_output_pin = div_pin_q;
  assign pwm_output_pin     = pwm_pin_q;
  assign timer_irq          = irq_q;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  sequence s_pwm_period_end;
    step && mode_q == TCP_MODE_PWM && ovf;
  endsequence

  a_pin_inverse: assert property (@(posedge clk) disable iff (!rst_b) // R05
    1'b1 |=> divider_output_pin == ~$past(ff_q))
    else $error("divider pin not inverse of flip-flop");

  a_pwm_pin_inv: assert property (@(posedge clk) disable iff (!rst_b) // R10
    1'b1 |=> pwm_output_pin == ~$past(ff_q))
    else $error("pwm pin not inverse of flip-flop");

  a_hold_stopped: assert property (@(posedge clk) disable iff (!rst_b) // R15
    !timer_run_bit_q |=> $stable(count_q))
    else $error("counter moved while stopped");

  a_match_clears: assert property (@(posedge clk) disable iff (!rst_b) // R03
    step && hit && mode_q != TCP_MODE_PWM |=> count_q == 8'h0 && irq_flag_q)
    else $error("match did not clear counter and flag");

  a_div_toggle: assert property (@(posedge clk) disable iff (!rst_b) // R04
    step && hit && mode_q == TCP_MODE_DIVIDER && !ff_preset |=> ff_q != $past(ff_q))
    else $error("divider flip-flop not toggled on match");

  a_pwm_no_clear: assert property (@(posedge clk) disable iff (!rst_b) // R08
    step && hit && !ovf && mode_q == TCP_MODE_PWM |=> count_q == $past(count_q) + 8'h1)
    else $error("pwm counter cleared on match");

  a_pwm_irq_ovf: assert property (@(posedge clk) disable iff (!rst_b) // R11
    s_pwm_period_end |=> irq_flag_q ##1 timer_irq)
    else $error("pwm overflow without interrupt");

  a_pwm_buffer: assert property (@(posedge clk) disable iff (!rst_b) // R12
    mode_q == TCP_MODE_PWM && !(step && ovf) && !run_rise
      |=> $stable(period_match_register_alias_q))
    else $error("active match changed mid period");

  a_run_load: assert property (@(posedge clk) disable iff (!rst_b) // R13
    run_rise |=> period_match_register_alias_q == $past(period_match_register_q))
    else $error("run did not load active match");

  a_timer_step: assert property (@(posedge clk) disable iff (!rst_b) // R01
    timer_run_bit_q && mode_q == TCP_MODE_TIMER && tick && !hit |=> count_q == $past(count_q) + 8'h1)
    else $error("timer did not step on internal tick");

  a_ext_step: assert property (@(posedge clk) disable iff (!rst_b) // R02
    timer_run_bit_q && mode_q == TCP_MODE_COUNTER && !ext_rise |=> $stable(count_q))
    else $error("counter moved without a pin edge");

  a_preset_ff: assert property (@(posedge clk) disable iff (!rst_b) // R06
    ff_preset |=> ff_q == $past(wb_req.dat[TCP_CTRL_FFVAL_POS]))
    else $error("flip-flop preset not applied");

  a_div_irq: assert property (@(posedge clk) disable iff (!rst_b) // R07
    step && hit && mode_q == TCP_MODE_DIVIDER |=> irq_flag_q)
    else $error("divider toggle without interrupt");

  a_pwm_wrap: assert property (@(posedge clk) disable iff (!rst_b) // R09
    s_pwm_period_end |=> count_q == 8'h0)
    else $error("pwm counter did not restart");

  a_pwm_ovf_toggle: assert property (@(posedge clk) disable iff (!rst_b) // R09
    step && ovf && !hit && mode_q == TCP_MODE_PWM && !ff_preset |=> ff_q != $past(ff_q))
    else $error("pwm flip-flop not toggled on overflow");

  a_pwm_hit_quiet: assert property (@(posedge clk) disable iff (!rst_b) // R11
    step && hit && !ovf && mode_q == TCP_MODE_PWM && !irq_flag_q |=> !irq_flag_q)
    else $error("pwm match raised interrupt");

endmodule
`default_nettype wire

// [core/tcp_pkg.sv]
package tcp_pkg;

  // -------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // -------------------------------------------------------------------
  localparam logic [7:0] TCP_OFF_CTRL  = 8'h00;
  localparam logic [7:0] TCP_OFF_MATCH = 8'h04;
  localparam logic [7:0] TCP_OFF_STAT  = 8'h08;
  localparam logic [7:0] TCP_OFF_COUNT = 8'h0c;

  // -------------------------------------------------------------------
  // control and status fields
  // -------------------------------------------------------------------
  localparam int TCP_CTRL_RUN_POS    = 0;
  localparam int TCP_CTRL_MODE_POS   = 1;
  localparam int TCP_CTRL_PRE_POS    = 4;
  localparam int TCP_CTRL_FFSET_POS  = 8;
  localparam int TCP_CTRL_FFVAL_POS  = 9;
  localparam int TCP_STAT_IRQ_POS    = 0;
  localparam int TCP_STAT_FF_POS     = 1;

  // -------------------------------------------------------------------
  // reset values and timing
  // -------------------------------------------------------------------
  localparam logic [7:0] TCP_MATCH_RST = 8'hff;
  localparam logic [3:0] TCP_PRE_RST   = 4'h0;
  localparam int         TCP_CLK_HZ    = 40000000;

  typedef enum logic [1:0] {
    TCP_MODE_TIMER,
    TCP_MODE_COUNTER,
    TCP_MODE_DIVIDER,
    TCP_MODE_PWM
  } tcp_mode_t;

  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        stb;
    logic        cyc;
  } tcp_wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
  } tcp_wb_rsp_t;

endpackage

// [core/tcp_pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module tcp_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // pin and result
  input  wire logic pin,
  output logic      rise
);

  logic [2:0] sync_q;
  logic       level_q;

  // stage 0 only feeds stage 1; a change counts once stages 1 and 2 agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], pin};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= 1'b0;
    end else if (sync_q[1] == sync_q[2]) begin
      level_q <= sync_q[2];
    end
  end

  assign rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q;

endmodule
`default_nettype wire

// [verif/timer_counter_pdo_pwm_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module timer_counter_pdo_pwm_tb;
  import tcp_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk;
  logic        rst_b;
  tcp_wb_req_t wb_req;
  tcp_wb_rsp_t wb_rsp;
  logic        external_count_input;
  logic        divider_output_pin;
  logic        pwm_output_pin;
  logic        timer_irq;
  int          errors;
  int          samples_checked;
  int          cycles;
  int          seed;
  int          t0;
  int          n;
  int          n_lo1;
  int          n_lo2;
  int          n_hi2;
  logic [7:0]  m;
  logic [7:0]  d1;
  logic [31:0] rd;
  logic [31:0] c0;

  tcp_timer dut_u (
    .clk                  (clk),
    .rst_b                (rst_b),
    .wb_req               (wb_req),
    .wb_rsp               (wb_rsp),
    .external_count_input (external_count_input),
    .divider_output_pin   (divider_output_pin),
    .pwm_output_pin       (pwm_output_pin),
    .timer_irq            (timer_irq)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task finish_test;
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard: whole run needs only a few thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // classic single cycle; entered just after a rising edge
  task wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int k;
    k = 0;
    wb_req.adr <= a;
    wb_req.we  <= we;
    wb_req.dat <= d;
    wb_req.sel <= 4'hf;
    wb_req.cyc <= 1'b1;
    wb_req.stb <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 50);
    rd = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    wb_req.we  <= 1'b0;
    @(posedge clk);
    if (k == 50) begin
      errors++;
      $display("MISMATCH %0t bus answer missing", $time);
    end
  endtask

  function logic pin(input logic p);
    return p ? pwm_output_pin : divider_output_pin;
  endfunction

  // cycles until the chosen pin shows lvl
  task wait_lvl(input logic p, input logic lvl, output int w);
    w = 0;
    while (pin(p) !== lvl && w < 2000) begin
      @(posedge clk);
      w++;
    end
    if (w == 2000) begin
      errors++;
      $display("MISMATCH %0t pin level never came", $time);
    end
  endtask

  task do_reset;
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  task pulse;
    external_count_input <= 1'b1;
    repeat (6) @(posedge clk);
    external_count_input <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  function logic [7:0] pick(input int lo, input int span);
    return 8'(lo + ($unsigned($random(seed)) % span));
  endfunction

  function logic [31:0] ctl(input logic [1:0] md, input logic run);
    return {29'h0, md, run};
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 47453;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    wb_req = '0;
    external_count_input = 1'b0;
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // reset state and an unmapped place
    check({30'h0, divider_output_pin, timer_irq}, 32'h2, "pins after reset");
    wb(TCP_OFF_MATCH, 1'b0, 32'h0);
    check(rd, {24'h0, TCP_MATCH_RST}, "match reset");
    wb(TCP_OFF_STAT, 1'b0, 32'h0);
    check(rd, 32'h0, "stat reset");
    wb(8'h10, 1'b1, 32'h5a);
    wb(8'h10, 1'b0, 32'h0);
    check(rd, 32'h0, "unmapped read");
    // timer: match period is m+1 ticks of 2^d1 clocks each
    m = pick(20, 41);
    d1 = pick(0, 3);
    wb(TCP_OFF_MATCH, 1'b1, {24'h0, m});
    wb(TCP_OFF_CTRL, 1'b1, ctl(TCP_MODE_TIMER, 1'b1) | {24'h0, d1[3:0], 4'h0});
    wb(TCP_OFF_STAT, 1'b1, 32'h1);
    for (int i = 0; i < 2; i++) begin
      n = 0;
      while (timer_irq !== 1'b1 && n < 500) begin
        @(posedge clk);
        n++;
      end
      if (i == 1) check(32'(cycles - t0), (32'(m) + 32'h1) << d1, "timer period");
      t0 = cycles;
      wb(TCP_OFF_STAT, 1'b1, 32'h1);
      // the pin copy lags the flag: let it fall before looking again
      while (timer_irq !== 1'b0 && n < 500) begin
        @(posedge clk);
        n++;
      end
    end
    wb(TCP_OFF_CTRL, 1'b1, ctl(TCP_MODE_COUNTER, 1'b0));
    wb(TCP_OFF_COUNT, 1'b0, 32'h0);
    c0 = rd;
    repeat (10) @(posedge clk);
    wb(TCP_OFF_COUNT, 1'b0, 32'h0);
    check(rd, c0, "stopped counter moved");
    // counter mode: pin edges only
    do_reset();
    wb(TCP_OFF_MATCH, 1'b1, 32'h5);
    wb(TCP_OFF_CTRL, 1'b1, ctl(TCP_MODE_COUNTER, 1'b1));
    repeat (20) @(posedge clk);
    repeat (4) pulse();
    wb(TCP_OFF_COUNT, 1'b0, 32'h0);
    check(rd, 32'h4, "edge count");
    repeat (2) pulse();
    wb(TCP_OFF_COUNT, 1'b0, 32'h0);
    check(rd, 32'h0, "count after match");
    wb(TCP_OFF_STAT, 1'b0, 32'h0);
    check(rd[0], 1'b1, "counter irq");
    // preset of the flip-flop
    wb(TCP_OFF_CTRL, 1'b1, 32'h300);
    @(posedge clk);
    check({31'h0, divider_output_pin}, 32'h0, "preset one pin");
    wb(TCP_OFF_CTRL, 1'b1, 32'h100);
    @(posedge clk);
    check({31'h0, pwm_output_pin}, 32'h1, "preset zero pin");
    // divider: high and low both m+1
    for (int i = 0; i < 3; i++) begin
      do_reset();
      m = pick(4, 37);
      wb(TCP_OFF_MATCH, 1'b1, {24'h0, m});
      wb(TCP_OFF_CTRL, 1'b1, ctl(TCP_MODE_DIVIDER, 1'b1));
      wait_lvl(1'b0, 1'b0, n);
      wait_lvl(1'b0, 1'b1, n);
      check(32'(n), 32'(m) + 32'h1, "divider low width");
      wait_lvl(1'b0, 1'b0, n);
      check(32'(n), 32'(m) + 32'h1, "divider high width");
      wb(TCP_OFF_STAT, 1'b1, 32'h1);
      wait_lvl(1'b0, 1'b1, n);
      repeat (2) @(posedge clk);
      check({31'h0, timer_irq}, 32'h1, "divider irq");
    end
    // pwm: buffered match, period 256
    do_reset();
    d1 = pick(150, 81);
    wb(TCP_OFF_MATCH, 1'b1, {24'h0, d1});
    wb(TCP_OFF_CTRL, 1'b1, ctl(TCP_MODE_PWM, 1'b1));
    wait_lvl(1'b1, 1'b0, n);
    wait_lvl(1'b1, 1'b1, n);
    wb(TCP_OFF_MATCH, 1'b1, {24'h0, d1 - 8'h64});
    wait_lvl(1'b1, 1'b0, n);
    wait_lvl(1'b1, 1'b1, n_lo1);
    check(32'(n_lo1), 32'h0ff - 32'(d1), "pwm duty");
    wait_lvl(1'b1, 1'b0, n_hi2);
    wait_lvl(1'b1, 1'b1, n_lo2);
    check(32'(n_hi2 + n_lo2), 32'h100, "pwm period");
    check(32'(n_lo2), 32'(n_lo1 + 100), "buffered duty step");
    // clear before the match so a match interrupt would still be seen
    wb(TCP_OFF_STAT, 1'b1, 32'h1);
    wait_lvl(1'b1, 1'b0, n);
    repeat (20) @(posedge clk);
    wb(TCP_OFF_STAT, 1'b0, 32'h0);
    check(rd[1:0], 2'h2, "no irq on match");
    check({31'h0, pwm_output_pin}, 32'h0, "pwm pin inverse");
    wait_lvl(1'b1, 1'b1, n);
    repeat (3) @(posedge clk);
    wb(TCP_OFF_STAT, 1'b0, 32'h0);
    check(rd[1:0], 2'h1, "irq on overflow");
    finish_test();
  end
endmodule
`default_nettype wire
